// ===== verilog/ufbcc_defines.svh
// constants for the user frame builder and check engine: register offsets,
// field positions, reset values and size limits.
// assumes inclusion by its bare name from the package and from the top module.
//
// Operation
// - fifteen frame entries, each send or receive
// - frame characters: letter, digit, control code
// - header longer than three characters is rejected
// - tail uses same set, at most three
// - direction undefined at reset, segments inactive
// - up to eight fixed or array segments
// - hex check one byte, ascii two
// - ascii check: high nibble first, uppercase
// - default sum: second byte to before check
// - range sum over configured start and end
// - range xor over configured positions
// - range product, low eight bits kept
// - masked variants apply mask at end
// - range positions name header, segment, tail
// - optional complement, mask after complement
// - mask by xor, or, and with the range word's mask value
// - frame limit 128 ascii, 256 hex
// - matched receive frame pulses flag, stores data
// - twos complement is inversion plus one
`ifndef UFBCC_DEFINES_SVH
`define UFBCC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------------
`define UFB_ADR_CMD 12'h000
`define UFB_ADR_STAT 12'h004
`define UFB_ADR_CTRL 12'h008
`define UFB_ADR_ENT_LO 12'h100
`define UFB_ADR_ENT_HI 12'h4C0
`define UFB_W_CFG 4'h0
`define UFB_W_HDR 4'h1
`define UFB_W_TAIL 4'h2
`define UFB_W_RANGE 4'h3
`define UFB_W_SEGT 4'h4
`define UFB_W_SEG0 4'h8

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define UFB_CMD_SEND 8
`define UFB_CFG_HLEN 2
`define UFB_CFG_TLEN 5
`define UFB_CFG_NSEG 8
`define UFB_CFG_BEN 12
`define UFB_CFG_ASC 13
`define UFB_CFG_RULE 14
`define UFB_CFG_CPL 17
`define UFB_CFG_MOP 19
`define UFB_RNG_END 8
`define UFB_RNG_MVAL 16
`define UFB_ST_FLAGS 8

// ----------------------------------------------------------------------------
// limits and reset values
// ----------------------------------------------------------------------------
`define UFB_NUM_ENT 15
`define UFB_MAX_TXT 3'd3
`define UFB_MAX_SEG 4'd8
`define UFB_IMG_LEN 16
`define UFB_LIM_ASC 9'd128
`define UFB_LIM_HEX 9'd256
`define UFB_RST_BYTE 8'h00

`endif

// ===== verilog/ufbcc_pkg.sv
// types for the user frame builder and check engine.
// assumes the defines header is reachable by bare name.
package ufbcc_pkg;
  `include "ufbcc_defines.svh"

  // top level sequencer
  typedef enum logic [2:0] {
    UFB_IDLE = 3'b001,
    UFB_SEND = 3'b010,
    UFB_SCAN = 3'b100
  } ufbcc_st_t;

  // frame direction
  typedef enum logic [1:0] {
    UFB_DIR_UNDEF = 2'b00,
    UFB_DIR_SEND = 2'b01,
    UFB_DIR_RECV = 2'b10
  } ufbcc_dir_t;

  // one frame table entry
  typedef struct packed {
    ufbcc_dir_t dir;
    logic [1:0] hlen;
    logic [1:0] tlen;
    logic [3:0] nseg;
    logic bcc_en;
    logic bcc_asc;
    logic [2:0] rule;
    logic [1:0] cpl;
    logic [1:0] mop;
    logic [7:0] mval;
    logic [4:0] rstart;
    logic [4:0] rend;
    logic [2:0][7:0] hdr;
    logic [2:0][7:0] tl;
    logic [7:0] segarr;
    logic [7:0][7:0] segfix;
    logic [7:0][7:0] mem;
  } ufbcc_entry_t;

  // block state apart from the frame table
  typedef struct packed {
    logic [14:0] ent_unused;
    ufbcc_st_t st;
    logic ack;
    logic [31:0] rdat;
    logic [3:0] cur;
    logic [4:0] pos;
    logic [7:0] txd;
    logic txv;
    logic [15:0][7:0] rxbuf;
    logic [8:0] rxcnt;
    logic [8:0] rxlen;
    logic rxdrop;
    logic rxpend;
    logic [14:0] match;
    logic [3:0] last;
    logic cfg_rej;
    logic rx_ovf;
    logic rx_nomatch;
    logic tx_ref;
    logic asc_mode;
  } ufbcc_ctl_t;
endpackage : ufbcc_pkg

// ===== verilog/ufbcc_top.sv
// user frame builder and matcher with configurable block check character.
// assumes a classic wishbone master on clk_i and byte streams from a serial
// engine on the same clock, so no input needs synchronising.
`timescale 1ns/100ps
`include "ufbcc_defines.svh"

module ufbcc_top
  import ufbcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_last_i,
  output logic rx_ready_o,
  output logic [14:0] match_o,
  output logic busy_o
);

  // --------------------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------------------

  // letter, decimal digit or allowed control code
  function automatic logic chr_ok(input logic [7:0] c);
    chr_ok = (c <= 8'h1F) || (c == 8'h7F)
      || (c >= 8'h30 && c <= 8'h39)
      || (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A);
  endfunction : chr_ok

  // position code (kind in [4:3], one based index in [2:0]) to byte index
  function automatic logic [4:0] pos_abs(input logic [4:0] pc, input logic [4:0] hl,
                                         input logic [4:0] ns);
    logic [4:0] idx;
    idx = {2'b00, pc[2:0]} - 5'd1;
    case (pc[4:3])
      2'b00: pos_abs = idx;
      2'b01: pos_abs = hl + idx;
      2'b10: pos_abs = hl + ns + idx;
      default: pos_abs = 5'h1F;
    endcase
  endfunction : pos_abs

  // one nibble to an uppercase ascii hex digit
  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    hex_chr = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_chr

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  ufbcc_ctl_t q_ff; // control and stream state
  ufbcc_ctl_t nxt_q; // next control state
  ufbcc_entry_t [14:0] tab_ff; // frame table
  ufbcc_entry_t [14:0] nxt_tab; // next frame table
  ufbcc_entry_t en; // entry under work
  logic [15:0][7:0] img; // image of the current entry's frame
  logic [4:0] img_len; // its length in bytes
  logic [7:0] chk; // final check value
  logic img_ok; // received frame equals the image
  logic [31:0] rd; // read mux
  logic [31:0] wmask; // byte lane mask
  logic [31:0] wd; // write data merged over the old value
  logic [11:0] aoff; // offset into the table window
  logic in_tab; // address falls in the table window
  logic [3:0] ae; // addressed entry
  logic [3:0] aw; // addressed word in the entry
  logic [4:0] hl; // header length
  logic [4:0] ns; // active segment count
  logic [4:0] tl; // tail length
  logic [4:0] blen; // frame length before the check
  logic [4:0] lo; // check range start
  logic [4:0] hi; // check range end
  logic [4:0] pb; // loop position
  logic [4:0] sx; // segment or tail offset
  logic [7:0] bv; // loop byte

  assign aoff = adr_i - `UFB_ADR_ENT_LO;
  assign in_tab = (adr_i >= `UFB_ADR_ENT_LO) && (adr_i < `UFB_ADR_ENT_HI);
  assign ae = aoff[9:6];
  assign aw = aoff[5:2];
  assign en = tab_ff[q_ff.cur];

  // --------------------------------------------------------------------------
  // frame image and check value of the current entry
  // --------------------------------------------------------------------------
  // the whole frame is built in one cycle; a frame is at most 16 bytes, far
  // below the 128 and 256 byte ceilings, so no length check is needed on send
  always_comb
  begin
    img = '0;
    chk = `UFB_RST_BYTE;
    hl = {3'b000, en.hlen};
    tl = {3'b000, en.tlen};
    ns = (en.dir == UFB_DIR_UNDEF) ? 5'd0 : {1'b0, en.nseg};
    blen = hl + ns + tl;
    sx = 5'd0;
    bv = `UFB_RST_BYTE;
    pb = 5'd0;
    if (en.rule == 3'd0)
    begin
      lo = 5'd1;
      hi = blen - 5'd1;
    end
    else
    begin
      lo = pos_abs(en.rstart, hl, ns);
      hi = pos_abs(en.rend, hl, ns);
    end
    // product starts at one, sum and xor at zero
    chk = (en.rule >= 3'd5) ? 8'h01 : 8'h00;
    for (int p = 0; p < `UFB_IMG_LEN; p++)
    begin
      pb = 5'(p);
      sx = 5'd0;
      if (pb < hl)
        bv = en.hdr[pb[1:0]];
      else if (pb < hl + ns)
      begin
        sx = pb - hl;
        // array bytes come from memory on send, from the line on receive
        if (en.segarr[sx[2:0]])
          bv = (q_ff.st == UFB_SCAN) ? q_ff.rxbuf[p] : en.mem[sx[2:0]];
        else
          bv = en.segfix[sx[2:0]];
      end
      else if (pb < blen)
      begin
        sx = pb - hl - ns;
        bv = en.tl[sx[1:0]];
      end
      else
        bv = `UFB_RST_BYTE;
      img[p] = bv;
      if (pb >= lo && pb <= hi && pb < blen)
      begin
        if (en.rule <= 3'd2)
          chk = chk + bv;
        else if (en.rule <= 3'd4)
          chk = chk ^ bv;
        else
          chk = 8'(chk * bv);
      end
    end
    // complement first, mask second
    if (en.cpl == 2'd1)
      chk = ~chk;
    else if (en.cpl == 2'd2)
      chk = ~chk + 8'h01;
    if (en.rule == 3'd2 || en.rule == 3'd4 || en.rule == 3'd6)
    begin
      case (en.mop)
        2'd0: chk = chk ^ en.mval;
        2'd1: chk = chk | en.mval;
        default: chk = chk & en.mval;
      endcase
    end
    img_len = blen;
    if (en.bcc_en)
    begin
      if (en.bcc_asc)
      begin
        img[blen[3:0]] = hex_chr(chk[7:4]);
        img[blen[3:0] + 4'd1] = hex_chr(chk[3:0]);
        img_len = blen + 5'd2;
      end
      else
      begin
        img[blen[3:0]] = chk;
        img_len = blen + 5'd1;
      end
    end
  end

  // received frame against the image: length, fixed bytes and
  always_comb
  begin
    img_ok = (q_ff.rxlen == {4'h0, img_len});
    for (int p = 0; p < `UFB_IMG_LEN; p++)
    begin
      if (5'(p) < img_len && img[p] != q_ff.rxbuf[p])
        img_ok = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // register read mux and byte lane merge
  // --------------------------------------------------------------------------
  always_comb
  begin
    rd = 32'h0000_0000;
    if (adr_i == `UFB_ADR_STAT)
      rd = {20'h00000, q_ff.tx_ref, q_ff.rx_nomatch, q_ff.rx_ovf, q_ff.cfg_rej,
            q_ff.last, 2'b00, q_ff.rxpend, (q_ff.st != UFB_IDLE)};
    else if (adr_i == `UFB_ADR_CTRL)
      rd = {31'h0, q_ff.asc_mode};
    else if (in_tab)
    begin
      case (aw)
        `UFB_W_CFG: rd = {11'h000, tab_ff[ae].mop, tab_ff[ae].cpl, tab_ff[ae].rule,
                          tab_ff[ae].bcc_asc, tab_ff[ae].bcc_en, tab_ff[ae].nseg,
                          1'b0, tab_ff[ae].tlen, 1'b0, tab_ff[ae].hlen, tab_ff[ae].dir};
        `UFB_W_HDR: rd = {8'h00, tab_ff[ae].hdr[2], tab_ff[ae].hdr[1], tab_ff[ae].hdr[0]};
        `UFB_W_TAIL: rd = {8'h00, tab_ff[ae].tl[2], tab_ff[ae].tl[1], tab_ff[ae].tl[0]};
        `UFB_W_RANGE: rd = {8'h00, tab_ff[ae].mval, 3'b000, tab_ff[ae].rend,
                            3'b000, tab_ff[ae].rstart};
        `UFB_W_SEGT: rd = {24'h000000, tab_ff[ae].segarr};
        default:
        begin
          if (aw >= `UFB_W_SEG0)
            rd = {16'h0000, tab_ff[ae].mem[aw[2:0]], tab_ff[ae].segfix[aw[2:0]]};
          else
            rd = 32'h0000_0000;
        end
      endcase
    end
    wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wd = (rd & ~wmask) | (dat_i & wmask);
  end

  // --------------------------------------------------------------------------
  // next state: bus slave, sequencer, receive collector, frame table
  // --------------------------------------------------------------------------
  always_comb
  begin
    nxt_q = q_ff;
    nxt_tab = tab_ff;
    nxt_q.match = 15'h0000;
    // bus: answer one cycle after the strobe, unmapped reads give zero
    nxt_q.ack = cyc_i && stb_i && !q_ff.ack;
    if (cyc_i && stb_i && !q_ff.ack)
    begin
      nxt_q.rdat = rd;
      if (we_i)
      begin
        if (adr_i == `UFB_ADR_CMD && sel_i[1] && dat_i[`UFB_CMD_SEND])
        begin
          // send only from idle and only a declared send entry
          if (q_ff.st == UFB_IDLE && dat_i[3:0] < 4'(`UFB_NUM_ENT)
              && tab_ff[dat_i[3:0]].dir == UFB_DIR_SEND)
          begin
            nxt_q.st = UFB_SEND;
            nxt_q.cur = dat_i[3:0];
            nxt_q.pos = 5'd0;
          end
          else
            nxt_q.tx_ref = 1'b1;
        end
        else if (adr_i == `UFB_ADR_STAT)
        begin
          // write one to clear, written lane only: a merged old one would wipe live
          // flags; an event in the same cycle is applied further down and wins
          if (sel_i[1] && dat_i[`UFB_ST_FLAGS]) nxt_q.cfg_rej = 1'b0;
          if (sel_i[1] && dat_i[`UFB_ST_FLAGS + 1]) nxt_q.rx_ovf = 1'b0;
          if (sel_i[1] && dat_i[`UFB_ST_FLAGS + 2]) nxt_q.rx_nomatch = 1'b0;
          if (sel_i[1] && dat_i[`UFB_ST_FLAGS + 3]) nxt_q.tx_ref = 1'b0;
        end
        else if (adr_i == `UFB_ADR_CTRL)
          nxt_q.asc_mode = wd[0];
        else if (in_tab)
        begin
          case (aw)
            `UFB_W_CFG:
            begin
              // lengths over three, more than eight segments, bad direction
              if (wd[`UFB_CFG_HLEN +: 3] > `UFB_MAX_TXT || wd[`UFB_CFG_TLEN +: 3] > `UFB_MAX_TXT
                  || wd[`UFB_CFG_NSEG +: 4] > `UFB_MAX_SEG || wd[1:0] == 2'b11)
                nxt_q.cfg_rej = 1'b1;
              else
              begin
                nxt_tab[ae].dir = ufbcc_dir_t'(wd[1:0]);
                nxt_tab[ae].hlen = wd[`UFB_CFG_HLEN +: 2];
                nxt_tab[ae].tlen = wd[`UFB_CFG_TLEN +: 2];
                nxt_tab[ae].nseg = wd[`UFB_CFG_NSEG +: 4];
                nxt_tab[ae].bcc_en = wd[`UFB_CFG_BEN];
                nxt_tab[ae].bcc_asc = wd[`UFB_CFG_ASC];
                nxt_tab[ae].rule = wd[`UFB_CFG_RULE +: 3];
                nxt_tab[ae].cpl = wd[`UFB_CFG_CPL +: 2];
                nxt_tab[ae].mop = wd[`UFB_CFG_MOP +: 2];
              end
            end
            `UFB_W_HDR, `UFB_W_TAIL:
            begin
              // all three characters must come from the allowed set
              if (!chr_ok(wd[7:0]) || !chr_ok(wd[15:8]) || !chr_ok(wd[23:16]))
                nxt_q.cfg_rej = 1'b1;
              else if (aw == `UFB_W_HDR)
                nxt_tab[ae].hdr = wd[23:0];
              else
                nxt_tab[ae].tl = wd[23:0];
            end
            `UFB_W_RANGE:
            begin
              nxt_tab[ae].rstart = wd[4:0];
              nxt_tab[ae].rend = wd[`UFB_RNG_END +: 5];
              nxt_tab[ae].mval = wd[`UFB_RNG_MVAL +: 8];
            end
            `UFB_W_SEGT: nxt_tab[ae].segarr = wd[7:0];
            default:
            begin
              if (aw >= `UFB_W_SEG0)
              begin
                nxt_tab[ae].segfix[aw[2:0]] = wd[7:0];
                nxt_tab[ae].mem[aw[2:0]] = wd[15:8];
              end
            end
          endcase
        end
      end
    end

    // sequencer
    case (q_ff.st)
      UFB_IDLE:
      begin
        // a send taken in this cycle goes first, the pending frame waits for it
        if (q_ff.rxpend && nxt_q.st == UFB_IDLE)
        begin
          nxt_q.st = UFB_SCAN;
          nxt_q.cur = 4'd0;
        end
      end
      UFB_SEND:
      begin
        // two cycles a byte: load, then wait for the taker
        if (!q_ff.txv)
        begin
          if (q_ff.pos < img_len)
          begin
            nxt_q.txd = img[q_ff.pos[3:0]];
            nxt_q.txv = 1'b1;
          end
          else
            nxt_q.st = UFB_IDLE;
        end
        else if (tx_ready_i)
        begin
          nxt_q.txv = 1'b0;
          nxt_q.pos = q_ff.pos + 5'd1;
        end
      end
      UFB_SCAN:
      begin
        // one entry a cycle; the lowest matching entry wins
        if (en.dir == UFB_DIR_RECV && img_ok)
        begin
          nxt_q.match[q_ff.cur] = 1'b1;
          nxt_q.last = q_ff.cur + 4'd1;
          for (int s = 0; s < 8; s++)
          begin
            if (en.segarr[s] && 4'(s) < en.nseg)
              nxt_tab[q_ff.cur].mem[s] = q_ff.rxbuf[{1'b0, en.hlen} + 4'(s)];
          end
          nxt_q.rxpend = 1'b0;
          nxt_q.st = UFB_IDLE;
        end
        else if (q_ff.cur == 4'(`UFB_NUM_ENT - 1))
        begin
          nxt_q.rx_nomatch = 1'b1;
          nxt_q.rxpend = 1'b0;
          nxt_q.st = UFB_IDLE;
        end
        else
          nxt_q.cur = q_ff.cur + 4'd1;
      end
      default: nxt_q.st = UFB_IDLE;
    endcase

    // receive collector; stalls while a frame waits to be matched
    if (rx_valid_i && rx_ready_o)
    begin
      if (q_ff.rxcnt < 9'(`UFB_IMG_LEN))
        nxt_q.rxbuf[q_ff.rxcnt[3:0]] = rx_data_i;
      if (q_ff.rxcnt >= (q_ff.asc_mode ? `UFB_LIM_ASC : `UFB_LIM_HEX))
      begin
        nxt_q.rxdrop = 1'b1;
        nxt_q.rx_ovf = 1'b1;
      end
      else
        nxt_q.rxcnt = q_ff.rxcnt + 9'd1;
      if (rx_last_i)
      begin
        nxt_q.rxlen = nxt_q.rxcnt;
        nxt_q.rxpend = !nxt_q.rxdrop;
        nxt_q.rxcnt = 9'd0;
        nxt_q.rxdrop = 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  // reset leaves every entry undefined with all segments inactive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_ff <= '0;
      q_ff.st <= UFB_IDLE;
      tab_ff <= '0;
    end
    else if (ce_i)
    begin
      q_ff <= nxt_q;
      tab_ff <= nxt_tab;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign dat_o = q_ff.rdat;
  assign ack_o = q_ff.ack;
  assign tx_data_o = q_ff.txd;
  assign tx_valid_o = q_ff.txv;
  assign rx_ready_o = !q_ff.rxpend && (q_ff.st != UFB_SCAN);
  assign match_o = q_ff.match;
  assign busy_o = (q_ff.st != UFB_IDLE);

endmodule : ufbcc_top

// ===== tb/ufbcc_monitor.sv
// port checker for the frame engine
// assumes a bind onto ufbcc_top and one clock domain
`timescale 1ns/100ps
module ufbcc_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ack_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic rx_valid_i,
  input wire logic rx_last_i,
  input wire logic rx_ready_o,
  input wire logic [14:0] match_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [8:0] rx_seen_ff; // bytes of the current frame taken so far
  // frames over the smaller limit may be dropped with no scan, so they are left out
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_seen_ff <= 9'h000;
    else if (rx_valid_i && rx_ready_o)
      rx_seen_ff <= rx_last_i ? 9'h000 : rx_seen_ff + 9'h001;
  end
  // flags blink for a single cycle only
  chk_match_pulse: assert property (match_o != 0 |=> match_o == 0)
    else $error("match flag held too long");
  chk_match_one: assert property ($onehot0(match_o))
    else $error("two match flags at once");
  chk_match_scan: assert property (match_o != 0 |-> $past(busy_o))
    else $error("match without a scan");
  chk_scan_bound: assert property (rx_valid_i && rx_last_i && rx_ready_o && rx_seen_ff < 9'h080
    |=> !rx_ready_o ##[1:24] rx_ready_o)
    else $error("frame never released");
  chk_reset_idle: assert property (disable iff (1'b0) rst_i |=> !busy_o && !tx_valid_o)
    else $error("busy out of reset");
  chk_tx_hold: assert property (tx_valid_o && !tx_ready_i
    |=> tx_valid_o && $stable(tx_data_o))
    else $error("send byte dropped");
  chk_tx_gap: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o)
    else $error("no gap after accept");
  chk_tx_busy: assert property (tx_valid_o |-> busy_o)
    else $error("byte sent while idle");
  chk_ack_once: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  cover property (match_o != 0);
  cover property (tx_valid_o && tx_ready_i);
  cover property (rx_valid_i && rx_last_i && rx_ready_o);
endmodule : ufbcc_monitor

// ===== tb/ufbcc_peer.sv
// far-end serial device: takes sent bytes, sends frames
// assumes the caller of send sits just after a rising edge
`timescale 1ns/100ps
module ufbcc_peer (
  input wire logic clk_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_last_o,
  input wire logic rx_ready_i
);
  logic [7:0] got[$]; // bytes taken from the engine
  int sd = 54492;
  initial
  begin
    tx_ready_o = 1'b0;
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_last_o = 1'b0;
  end
  // random stalls, one cycle in four, keep the hold path busy
  always @(posedge clk_i)
  begin
    if (tx_valid_i && tx_ready_o)
      got.push_back(tx_data_i);
    tx_ready_o <= ($random(sd) % 4) != 0;
  end
  // frames go out in declared order, header to
  task send(input logic [7:0] f[$]);
    for (int i = 0; i < f.size(); i++)
    begin
      rx_valid_o <= 1'b1;
      rx_data_o <= f[i];
      rx_last_o <= (i == f.size() - 1);
      do @(posedge clk_i); while (rx_ready_i !== 1'b1);
    end
    rx_valid_o <= 1'b0;
    rx_last_o <= 1'b0;
    rx_data_o <= ~f[f.size() - 1]; // released line: no stale byte
  endtask : send
endmodule : ufbcc_peer

// ===== tb/ufbcc_tb_top.sv
// self-checking bench: wishbone setup, send and receive frames
// assumes the peer model and the checker are compiled alongside
`timescale 1ns/100ps
module ufbcc_tb_top;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0, dat_o;
  logic ack_o, tx_valid, tx_ready, rx_valid, rx_last, rx_ready, busy_o;
  logic [7:0] tx_data, rx_data, b[6];
  logic [14:0] match_o;
  int n_errors = 0, n_compared = 0, seed = 54492;
  always #20 clk_i = ~clk_i;
  ufbcc_top u_ufbcc_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o),
    .ack_o(ack_o), .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_last_i(rx_last),
    .rx_ready_o(rx_ready), .match_o(match_o), .busy_o(busy_o));
  ufbcc_peer u_ufbcc_peer (.clk_i(clk_i), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_last_o(rx_last), .rx_ready_i(rx_ready));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task close_out;
    if (n_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // one classic cycle; request held until ack is sampled
  task wb(input logic w, input int a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= 12'(a);
    dat <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // expected check over b[]: default skips the first byte
  function automatic logic [7:0] bcc(input int rule, cpl, mop, input logic [7:0] mv);
    logic [7:0] v;
    v = (rule > 4) ? 8'h01 : 8'h00;
    for (int i = (rule == 0); i < 6; i++)
      v = (rule > 4) ? v * b[i] : (rule > 2) ? v ^ b[i] : v + b[i];
    v = (cpl == 1) ? ~v : (cpl == 2) ? ~v + 8'h01 : v;
    if (rule != 0 && rule % 2 == 0)
      v = (mop == 0) ? v ^ mv : (mop == 1) ? v | mv : v & mv;
    return v;
  endfunction : bcc
  function automatic logic [7:0] hc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction : hc
  initial
  begin
    #(40 * 60000);
    n_errors++; // hang
    close_out();
  end
  initial
  begin
    int rule, cpl, mop, asc, n;
    logic [31:0] r;
    logic [7:0] mv, v;
    logic [7:0] fr[$];
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(busy_o, 0);
    chk(rx_ready, 1);
    wb(0, 'h100, 0, r); chk(r, 0);
    wb(0, 'h480, 0, r); chk(r, 0);
    wb(0, 'h0FC, 0, r); chk(r, 0);
    // bad lengths and characters are refused, 7F is fine
    for (int k = 0; k < 5; k++)
    begin
      wb(1, 'h004, 32'hF00, r);
      case (k)
        0: wb(1, 'h180, 32'h10, r);
        1: wb(1, 'h180, 32'h80, r);
        2: wb(1, 'h184, 32'h20, r);
        3: wb(1, 'h188, 32'h7E, r);
        default: wb(1, 'h184, 32'h7F, r);
      endcase
      wb(0, 'h004, 0, r); chk(r[8], k != 4);
    end
    wb(1, 'h000, 32'h102, r);
    wb(0, 'h004, 0, r); chk(r[11], 1);
    // every rule once, then random settings
    for (int it = 0; it < 14; it++)
    begin
      rule = (it < 7) ? it : $unsigned($random(seed)) % 7;
      cpl = (it == 0) ? 0 : $unsigned($random(seed)) % 3;
      mop = $unsigned($random(seed)) % 3;
      asc = it % 2;
      mv = 8'($random(seed));
      b[0] = 8'h05;
      b[5] = 8'h04;
      for (int k = 1; k < 5; k++)
        b[k] = 8'($random(seed));
      for (int e = 0; e < 2; e++)
      begin
        wb(1, 'h100 + e * 64, 32'((e + 1) | 32'h1424 | asc << 13 | rule << 14
          | cpl << 17 | mop << 19), r);
        wb(1, 'h104 + e * 64, 32'h05, r);
        wb(1, 'h108 + e * 64, 32'h04, r);
        wb(1, 'h10C + e * 64, 32'h1101 | 32'(mv) << 16, r);
        wb(1, 'h110 + e * 64, 32'(e * 15), r);
        for (int k = 0; k < 4; k++)
          wb(1, 'h120 + e * 64 + k * 4, 32'(b[k + 1]), r);
      end
      fr = {b[0], b[1], b[2], b[3], b[4], b[5]};
      v = bcc(rule, cpl, mop, mv);
      if (asc)
        fr = {fr, hc(v[7:4]), hc(v[3:0])};
      else
        fr.push_back(v);
      u_ufbcc_peer.got.delete();
      wb(1, 'h000, 32'h100, r);
      n = 0;
      do @(posedge clk_i); while (busy_o !== 1'b0 && ++n < 2000);
      repeat (3) @(posedge clk_i);
      chk(busy_o, 0);
      chk(u_ufbcc_peer.got.size(), fr.size());
      for (int k = 0; k < fr.size(); k++)
        chk(u_ufbcc_peer.got[k], fr[k]);
      for (int bad = 0; bad < 2; bad++)
      begin
        if (bad)
          fr[fr.size() - 1] ^= 8'h01;
        u_ufbcc_peer.send(fr);
        n = 0;
        repeat (24) @(posedge clk_i) n += match_o[1];
        chk(n, !bad);
      end
      wb(0, 'h160, 0, r); chk(r[15:8], b[1]);
    end
    // 128 bytes fit an ascii link and 256 a hex one; one byte more overruns
    for (int t = 0; t < 4; t++)
    begin
      wb(1, 'h008, 32'(t < 2), r);
      wb(1, 'h004, 32'hF00, r);
      fr.delete();
      repeat ((t < 2 ? 128 : 256) + t % 2) fr.push_back(8'h41);
      u_ufbcc_peer.send(fr);
      repeat (20) @(posedge clk_i);
      wb(0, 'h004, 0, r); chk(r[9], t % 2);
    end
    close_out();
  end
endmodule : ufbcc_tb_top
bind ufbcc_top ufbcc_monitor u_ufbcc_monitor (.clk_i(clk_i), .rst_i(rst_i), .ack_o(ack_o),
  .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
  .rx_valid_i(rx_valid_i), .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o),
  .match_o(match_o), .busy_o(busy_o));
